// File: hdl/ubrk_pkg.sv
// package: constants, types and register map of the break block
package ubrk_pkg;

  // register offsets on the plain register port
  localparam logic [3:0] UBRK_OFS_CTRL   = 4'h0;
  localparam logic [3:0] UBRK_OFS_TXDATA = 4'h1;
  localparam logic [3:0] UBRK_OFS_STATUS = 4'h2;
  localparam logic [3:0] UBRK_OFS_MASK   = 4'h3;
  localparam logic [3:0] UBRK_OFS_BAUD   = 4'h4;

  // control register field positions
  localparam int UBRK_CTRL_TX_PATH_ENABLE   = 0;
  localparam int UBRK_CTRL_SEND_BREAK_REQUEST  = 1;
  localparam int UBRK_CTRL_OVR    = 2;
  localparam int UBRK_CTRL_TIMSEL = 3;
  localparam int UBRK_CTRL_WAKE   = 4;
  localparam int UBRK_CTRL_MODE   = 5;

  // status register field positions (sticky, write one to clear)
  localparam int UBRK_ST_RXBRK  = 0;
  localparam int UBRK_ST_TXIDLE = 1;
  localparam int UBRK_ST_RXBYTE = 2;
  localparam int UBRK_ST_WIDTH  = 3;

  // values after reset
  localparam logic [7:0]  UBRK_CTRL_RST = 8'h00;
  localparam logic [15:0] UBRK_BAUD_RST = 16'h01B2;

  // break lengths in bit periods
  localparam logic [4:0] UBRK_TX_ZEROS   = 5'h0C;
  localparam logic [4:0] UBRK_RX_THR_STD = 5'h0B;
  localparam logic [4:0] UBRK_RX_THR_DMX = 5'h17;

  // framing modes
  typedef enum logic [1:0] {
    UBRK_MODE_ASYNC = 2'h0,
    UBRK_MODE_LIN   = 2'h1,
    UBRK_MODE_DMX   = 2'h2
  } ubrk_mode_t;

  // transmitter states, one-hot
  typedef enum logic [3:0] {
    UBRK_TX_IDLE  = 4'h1,
    UBRK_TX_BREAK = 4'h2,
    UBRK_TX_CHAR  = 4'h4,
    UBRK_TX_STOP  = 4'h8
  } ubrk_txst_t;

  // register port request carried as one bundle
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } ubrk_req_t;

endpackage

// File: hdl/ubrk_rx_break.sv
// receive-side break detector: space-length counter and flag timing
`timescale 1ns/100ps
`default_nettype none
module ubrk_rx_break
  import ubrk_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // bit timing and settings
  input  wire logic        bit_tick,
  input  wire logic        rx_sync,
  input  wire logic        dmx_mode,
  input  wire logic        flag_at_detect,
  // result
  output logic             break_event,
  output logic             in_break
);

  logic [4:0] space_count;   // whole bit periods of space seen
  logic       detected;      // threshold reached in this space run
  logic       rx_prev;       // last sampled line level

  // threshold picked by framing mode
  // mode threshold
  wire [4:0] threshold = dmx_mode ? UBRK_RX_THR_DMX : UBRK_RX_THR_STD;
  wire       reach     = bit_tick && !rx_sync && !detected &&
                         (space_count + 5'h01 >= threshold);
  wire       rise      = rx_sync && !rx_prev;

  assign break_event = flag_at_detect ? reach : (rise && detected);
  assign in_break    = detected;

  // count space periods; any mark sample restarts the run
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      space_count <= 5'h00;
      detected    <= 1'b0;
      rx_prev     <= 1'b1;
    end else begin
      rx_prev <= rx_sync;
      if (rx_sync) begin
        space_count <= 5'h00;
        detected    <= 1'b0;
      end else if (bit_tick && !detected) begin
        space_count <= space_count + 5'h01;
        if (reach) begin
          detected <= 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// File: hdl/ubrk_top.sv
// serial port break generation and detection with register port
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module ubrk_top
  import ubrk_pkg::*;
(
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  // register port
  input  wire logic [3:0]  ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [15:0] RDATA,
  // serial line
  input  wire logic        RX_PIN,
  output logic             TX_PIN,
  // power state
  input  wire logic        SLEEP,
  // events
  output logic             IRQ,
  output logic             WAKE
);

  ubrk_req_t  req;           // bundled register request
  logic [7:0] ctrl;          // control register
  logic [15:0] baud;         // clocks per bit minus one
  logic [2:0] status;        // sticky event bits
  logic [2:0] mask;          // interrupt enables
  logic [7:0] rx_byte;       // last received character
  logic [15:0] rdata_q;      // registered read data
  logic       rx_meta;       // first synchroniser stage
  logic       rx_sync;       // second synchroniser stage
  logic       sleep_meta;    // sleep input first stage
  logic       sleep_sync;    // sleep input second stage
  logic [15:0] div_cnt;      // bit period divider
  ubrk_txst_t tx_state;      // transmitter state
  logic [3:0] tx_bits;       // bits left in current phase
  logic [4:0] brk_bits;      // break zeros left
  logic [7:0] tx_shift;      // character shift register
  logic       tx_line;       // registered line level
  logic       tx_is_break;   // current frame carries a break
  logic       rx_busy;       // receiving a character
  logic [3:0] rx_bits;       // receive bit index
  logic [15:0] rx_div;       // receive sampling divider
  logic [7:0] rx_shift;      // receive shifter

  // bundle the port so every decode below reads one carrier
  assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  // decoded control fields
  wire        tx_path_enable      = ctrl[UBRK_CTRL_TX_PATH_ENABLE];
  wire        send_break_request     = ctrl[UBRK_CTRL_SEND_BREAK_REQUEST];
  wire        ovr       = ctrl[UBRK_CTRL_OVR];
  wire        timsel    = ctrl[UBRK_CTRL_TIMSEL];
  wire        wake_en   = ctrl[UBRK_CTRL_WAKE];
  wire [1:0]  mode      = ctrl[UBRK_CTRL_MODE +: 2];
  // no send break in LIN, DMX
  wire        auto_mode = (mode == UBRK_MODE_LIN) || (mode == UBRK_MODE_DMX);
  wire        dmx_mode  = (mode == UBRK_MODE_DMX);

  // register address decode
  // a stale address with no strobe decodes to nothing
  wire wr_ctrl   = req.wr && (req.addr == UBRK_OFS_CTRL);
  wire wr_txdata = req.wr && (req.addr == UBRK_OFS_TXDATA);
  wire wr_status = req.wr && (req.addr == UBRK_OFS_STATUS);
  wire wr_mask   = req.wr && (req.addr == UBRK_OFS_MASK);
  wire wr_baud   = req.wr && (req.addr == UBRK_OFS_BAUD);

  wire run       = !sleep_sync;
  wire bit_tick  = run && (div_cnt == 16'h0000);
  wire tx_idle   = (tx_state == UBRK_TX_IDLE);

  // fixed break armed by buffer write
  wire start_tx  = wr_txdata && tx_path_enable && tx_idle && run && !wake_en;
  wire start_brk = start_tx && send_break_request && !auto_mode;
  // last stop tick of any frame, break or character
  wire frame_end = bit_tick && (tx_state == UBRK_TX_STOP) &&
                   (tx_bits == 4'h1);
  wire brk_done  = frame_end && tx_is_break;

  // receive break detector events
  logic brk_event;
  logic in_break;
  wire  rx_done;
  wire  rx_active = run && !wake_en;

  ubrk_rx_break ubrk_rx_break_i (
    .clk            (CORE_CLK),
    .rst            (RST),
    .bit_tick       (bit_tick && rx_active),
    .rx_sync        (rx_sync),
    .dmx_mode       (dmx_mode),
    .flag_at_detect (timsel),
    .break_event    (brk_event),
    .in_break       (in_break)
  );

  // idle flag is a plain level
  // events feeding the sticky status: set wins over clear
  wire [2:0] set_ev  = {rx_done, frame_end, brk_event && rx_active};
  wire [2:0] next_status = (status & ~(wr_status ? req.wdata[2:0] : 3'h0))
                           | set_ev;

  // read multiplexer
  wire [15:0] read_mux =
    (req.addr == UBRK_OFS_CTRL)   ? {8'h00, ctrl} :
    (req.addr == UBRK_OFS_TXDATA) ? {8'h00, rx_byte} :
    (req.addr == UBRK_OFS_STATUS) ? {11'h000, tx_idle, in_break, status} :
    (req.addr == UBRK_OFS_MASK)   ? {13'h0000, mask} :
    (req.addr == UBRK_OFS_BAUD)   ? baud : 16'h0000;

  assign RDATA = rdata_q;
  assign IRQ   = |(status & mask);
  // wake level: high while armed and the line sits in space
  // not latched, so a very short space may be missed by polling
  assign WAKE  = wake_en && !rx_sync;

  assign TX_PIN = ovr ? 1'b0 : tx_line;

  // two-stage synchronisers for pin inputs
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      rx_meta    <= 1'b1;
      rx_sync    <= 1'b1;
      sleep_meta <= 1'b0;
      sleep_sync <= 1'b0;
    end else begin
      rx_meta    <= RX_PIN;
      rx_sync    <= rx_meta;
      sleep_meta <= SLEEP;
      sleep_sync <= sleep_meta;
    end
  end

  // register file and read data
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ctrl    <= UBRK_CTRL_RST;
      baud    <= UBRK_BAUD_RST;
      mask    <= 3'h0;
      status  <= 3'h0;
      rdata_q <= 16'h0000;
    end else begin
      status  <= next_status;
      rdata_q <= req.rd ? read_mux : 16'h0000;
      if (wr_mask) begin
        mask <= req.wdata[2:0];
      end
      if (wr_baud) begin
        baud <= req.wdata;
      end
      // a control write in the clearing cycle keeps what software wrote
      if (wr_ctrl) begin
        ctrl <= req.wdata[7:0];
      end else if (brk_done) begin
        ctrl[UBRK_CTRL_SEND_BREAK_REQUEST] <= 1'b0;
      end
    end
  end

  // bit period divider, shared by both directions
  // a new rate takes effect only at the next reload, so the first
  // bit after a rate change may run long; change rate while idle
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      div_cnt <= 16'h0000;
    end else if (!run || div_cnt == 16'h0000) begin
      div_cnt <= baud;
    end else begin
      div_cnt <= div_cnt - 16'h0001;
    end
  end

  // transmitter: start bit, break zeros or data, stop bit
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      tx_state    <= UBRK_TX_IDLE;
      tx_bits     <= 4'h0;
      brk_bits    <= 5'h00;
      tx_shift    <= 8'h00;
      tx_line     <= 1'b1;
      tx_is_break <= 1'b0;
    end else if (!run) begin
      tx_state <= UBRK_TX_IDLE;
      tx_line  <= 1'b1;
    end else begin
      case (tx_state)
        UBRK_TX_IDLE: begin
          if (start_tx) begin
            // character is latched now even when a break goes first
            tx_shift    <= req.wdata[7:0];
            tx_is_break <= start_brk;
            tx_line     <= 1'b0;
            brk_bits    <= UBRK_TX_ZEROS;
            tx_bits     <= 4'h8;
            tx_state    <= start_brk ? UBRK_TX_BREAK : UBRK_TX_CHAR;
          end
        end
        UBRK_TX_BREAK: begin
          if (bit_tick) begin
            brk_bits <= brk_bits - 5'h01;
            if (brk_bits == 5'h00) begin
              tx_line  <= 1'b1;
              tx_bits  <= 4'h1;
              tx_state <= UBRK_TX_STOP;
            end
          end
        end
        UBRK_TX_CHAR: begin
          if (bit_tick) begin
            tx_line  <= tx_shift[0];
            tx_shift <= {1'b0, tx_shift[7:1]};
            tx_bits  <= tx_bits - 4'h1;
            if (tx_bits == 4'h0) begin
              tx_line  <= 1'b1;
              tx_bits  <= 4'h1;
              tx_state <= UBRK_TX_STOP;
            end
          end
        end
        UBRK_TX_STOP: begin
          if (frame_end) begin
            if (tx_is_break) begin
              tx_is_break <= 1'b0;
              tx_line     <= 1'b0;
              tx_bits     <= 4'h8;
              tx_state    <= UBRK_TX_CHAR;
            end else begin
              tx_state <= UBRK_TX_IDLE;
            end
          end
        end
        default: begin
          tx_state <= UBRK_TX_IDLE;
          tx_line  <= 1'b1;
        end
      endcase
    end
  end

  // minimal receiver; mid-bit sampling off the start edge
  // a detected break holds it off so no false byte is stored
  // held idle while wake enable set
  assign rx_done = rx_busy && rx_active && (rx_div == 16'h0000) &&
                   (rx_bits == 4'h9) && rx_sync;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      rx_busy  <= 1'b0;
      rx_bits  <= 4'h0;
      rx_div   <= 16'h0000;
      rx_shift <= 8'h00;
      rx_byte  <= 8'h00;
    end else if (!rx_active || in_break) begin
      rx_busy <= 1'b0;
    end else if (!rx_busy) begin
      if (!rx_sync) begin
        rx_busy <= 1'b1;
        rx_bits <= 4'h0;
        rx_div  <= {1'b0, baud[15:1]};
      end
    end else if (rx_div != 16'h0000) begin
      rx_div <= rx_div - 16'h0001;
    end else begin
      rx_div  <= baud;
      rx_bits <= rx_bits + 4'h1;
      if (rx_bits != 4'h0 && rx_bits != 4'h9) begin
        rx_shift <= {rx_sync, rx_shift[7:1]};
      end
      if (rx_bits == 4'h9) begin
        rx_busy <= 1'b0;
        if (rx_sync) begin
          rx_byte <= rx_shift;
        end
      end
    end
  end

endmodule
`default_nettype wire

// File: testbench/ubrk_top_props.sv
// checker: port-level properties of the break block
`timescale 1ns/100ps
`default_nettype none
module ubrk_top_props
  import ubrk_pkg::*;
(
  // clock, reset and register port
  input wire logic        CORE_CLK,
  input wire logic        RST,
  input wire logic [3:0]  ADDR,
  input wire logic [15:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [15:0] RDATA,
  // line, power and events
  input wire logic        RX_PIN,
  input wire logic        TX_PIN,
  input wire logic        SLEEP,
  input wire logic        IRQ,
  input wire logic        WAKE
);
  logic [7:0]  ctl;   // control as last written
  logic [2:0]  msk;   // mask as last written
  logic [15:0] baud;  // divider as last written
  logic [15:0] rx_lo; // cycles of unbroken space on rx
  logic [15:0] tx_lo; // cycles of tx space outside override
  wire  [15:0] bp  = baud + 16'h1;
  // first tick may come right after the edge, so one period less is allowed
  wire  [15:0] thr = 16'((ctl[6:5] == 2'h2 ? 22 : 10) * bp);
  wire         ovr = ctl[UBRK_CTRL_OVR];
  wire         wk  = ctl[UBRK_CTRL_WAKE];
  wire         tim = ctl[UBRK_CTRL_TIMSEL];
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // shadows follow the port; counters saturate
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ctl   <= UBRK_CTRL_RST;
      msk   <= 3'h7;  // unknown until written, so no claim
      baud  <= UBRK_BAUD_RST;
      rx_lo <= 16'h0;
      tx_lo <= 16'h0;
    end else begin
      ctl   <= (WR && ADDR == UBRK_OFS_CTRL) ? WDATA[7:0] : ctl;
      msk   <= (WR && ADDR == UBRK_OFS_MASK) ? WDATA[2:0] : msk;
      baud  <= (WR && ADDR == UBRK_OFS_BAUD) ? WDATA : baud;
      rx_lo <= RX_PIN ? 16'h0 : rx_lo + 16'(rx_lo != 16'hFFFF);
      tx_lo <= (TX_PIN || ovr) ? 16'h0 : tx_lo + 16'(tx_lo != 16'hFFFF);
    end
  end
  a_ovr_space: assert property (ovr |-> !TX_PIN)
    else $error("tx not space under override");
  a_brk_len: assert property ($rose(TX_PIN) |-> tx_lo <= 16'(13 * bp))
    else $error("tx space run longer than a break");
  a_rd_quiet: assert property (!$past(RD) |-> RDATA == 16'h0)
    else $error("read data outside read slot");
  a_rd_unmapped: assert property (RD && ADDR > UBRK_OFS_BAUD |=> !RDATA)
    else $error("unmapped read not zero");
  a_ctrl_back: assert property (RD && ADDR == UBRK_OFS_CTRL |=>
    RDATA[15:7] == 9'h0 && RDATA[6:2] == ctl[6:2] && RDATA[0] == ctl[0])
    else $error("control readback wrong");
  a_irq_masked: assert property (msk == 3'h0 |-> !IRQ)
    else $error("irq with all masked");
  a_wake_gate: assert property (!wk && !$past(wk) |-> !WAKE)
    else $error("wake without enable");
  a_flag_early: assert property ($rose(IRQ) && msk == 3'h1 &&
    $past(msk) == 3'h1 && tim |-> rx_lo >= thr)
    else $error("break flag before threshold");
  a_flag_mark: assert property ($rose(IRQ) && msk == 3'h1 &&
    $past(msk) == 3'h1 && !tim |-> RX_PIN)
    else $error("break flag before return to mark");
  a_sleep_still: assert property (SLEEP [*5] ##0 !ovr && !$past(ovr)
    |-> $stable(TX_PIN))
    else $error("tx moved during sleep");
endmodule
bind ubrk_top ubrk_top_props ubrk_top_props_i (.CORE_CLK(CORE_CLK),
  .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .RX_PIN(RX_PIN), .TX_PIN(TX_PIN), .SLEEP(SLEEP), .IRQ(IRQ), .WAKE(WAKE));
`default_nettype wire

// File: testbench/ubrk_node.sv
// partner: remote serial node driving rx and timing tx space runs
`timescale 1ns/100ps
`default_nettype none
module ubrk_node #(
  parameter int BP = 4  // clocks per bit on the line
) (
  // clock and line
  input  wire logic clk,
  input  wire logic tx_line,
  output var logic  rx_line
);
  int cnt;     // length of the current tx space run
  int runs[$]; // finished tx space runs, in clocks
  // an idle line rests at mark
  initial rx_line = 1'b1;
  // time every space run of the transmit line
  always @(posedge clk) begin
    if (!tx_line) begin
      cnt++;
    end else if (cnt != 0) begin
      runs.push_back(cnt);
      cnt = 0;
    end
  end
  // hold the line at one level for whole bit periods
  task automatic hold(input logic lvl, input int nbits);
    rx_line <= lvl;
    repeat (nbits * BP) @(posedge clk);
    #1;
  endtask
endmodule
`default_nettype wire

// File: testbench/test_uart_break_gen_detect.sv
// testbench: break generation and detection through the ports
`timescale 1ns/100ps
`default_nettype none
module test_uart_break_gen_detect
  import ubrk_pkg::*;
;
  localparam int BP = 4; // short bit keeps the run brief
  logic        clk, rst, wr, rd, slp, rx, tx, irq, wake;
  logic [3:0]  addr;
  logic [15:0] wdata, rdata, d;
  int          bad_count, cmp_count, cyc;
  ubrk_top ubrk_top_i (.CORE_CLK(clk), .RST(rst), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .RX_PIN(rx),
    .TX_PIN(tx), .SLEEP(slp), .IRQ(irq), .WAKE(wake));
  ubrk_node #(.BP(BP)) ubrk_node_i (.clk(clk), .tx_line(tx), .rx_line(rx));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // a hang ends the run; all tests together need about 1500 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      final_report();
    end
  end
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rreg(input logic [3:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // wait for n finished tx space runs
  task automatic wait_runs(input int n);
    repeat (900) if (ubrk_node_i.runs.size() < n) @(posedge clk);
    #1;
    chk("run count", 16'(ubrk_node_i.runs.size()), 16'(n));
  endtask
  task automatic t_regs();
    rreg(UBRK_OFS_CTRL);
    chk("ctrl rst", d, 16'(UBRK_CTRL_RST));
    rreg(UBRK_OFS_BAUD);
    chk("baud rst", d, UBRK_BAUD_RST);
    wreg(4'hF, 16'hFFFF);
    rreg(4'hF);
    chk("unmapped", d, 16'h0);
    wreg(UBRK_OFS_BAUD, 16'(BP - 1));
    // the free divider finishes its old period before the new rate
    tk(int'(UBRK_BAUD_RST) + 2);
    wreg(UBRK_OFS_MASK, 16'h0);
    rreg(UBRK_OFS_CTRL);
    chk("ctrl", d, 16'h0);
  endtask
  task automatic t_fixed();
    ubrk_node_i.runs.delete();
    wreg(UBRK_OFS_CTRL, 16'h3);
    tk(3 * BP);
    chk("tx before write", 16'(tx), 16'h1);
    wreg(UBRK_OFS_TXDATA, 16'h55);
    tk(2 * BP);
    rreg(UBRK_OFS_STATUS);
    chk("idle in break", 16'(d[4]), 16'h0);
    rreg(UBRK_OFS_CTRL);
    chk("request held", 16'(d[UBRK_CTRL_SEND_BREAK_REQUEST]), 16'h1);
    wait_runs(1);
    chk("break", 16'(ubrk_node_i.runs[0] inside {[12*BP:13*BP]}), 16'h1);
    tk(BP + 2);
    rreg(UBRK_OFS_CTRL);
    chk("request clear", 16'(d[UBRK_CTRL_SEND_BREAK_REQUEST]), 16'h0);
    wait_runs(6);
    for (int i = 1; i < 6; i++) begin
      chk("char bit", 16'(ubrk_node_i.runs[i]), 16'(BP));
    end
    tk(2 * BP);
    rreg(UBRK_OFS_STATUS);
    chk("idle after", 16'({d[4], d[UBRK_ST_TXIDLE]}), 16'h3);
  endtask
  task automatic t_modes();
    for (int m = 1; m < 3; m++) begin
      ubrk_node_i.runs.delete();
      wreg(UBRK_OFS_CTRL, 16'(m << UBRK_CTRL_MODE) | 16'h3);
      wreg(UBRK_OFS_TXDATA, 16'hFF);
      wait_runs(1);
      chk("no break", 16'(ubrk_node_i.runs[0] <= BP), 16'h1);
      tk(12 * BP);
    end
    wreg(UBRK_OFS_CTRL, 16'h0);
  endtask
  task automatic t_ovr();
    wreg(UBRK_OFS_CTRL, 16'h5);
    tk(20 * BP);
    chk("held space", 16'(tx), 16'h0);
    wreg(UBRK_OFS_CTRL, 16'h1);
    chk("back to mark", 16'(tx), 16'h1);
  endtask
  // mode, timing select, space, second space, flag in space, at mark
  task automatic t_rx();
    int cs[7][6] = '{'{0,1,10,0,0,0}, '{0,1,12,0,1,1}, '{0,0,12,0,0,1},
      '{2,1,22,0,0,0}, '{2,1,24,0,1,1}, '{0,1,8,8,0,0}, '{1,1,12,0,1,1}};
    wreg(UBRK_OFS_MASK, 16'h1);
    foreach (cs[i]) begin
      wreg(UBRK_OFS_CTRL, 16'((cs[i][0] << 5) | (cs[i][1] << 3)));
      wreg(UBRK_OFS_STATUS, 16'h7);
      ubrk_node_i.hold(1'b0, cs[i][2]);
      if (cs[i][3] != 0) begin
        ubrk_node_i.hold(1'b1, 1);
        ubrk_node_i.hold(1'b0, cs[i][3]);
      end
      chk("flag in space", 16'(irq), 16'(cs[i][4]));
      ubrk_node_i.hold(1'b1, 3);
      chk("flag at mark", 16'(irq), 16'(cs[i][5]));
      wreg(UBRK_OFS_MASK, 16'h0);
      chk("masked", 16'(irq), 16'h0);
      wreg(UBRK_OFS_MASK, 16'h1);
      wreg(UBRK_OFS_STATUS, 16'h1);
      chk("cleared", 16'(irq), 16'h0);
    end
  endtask
  task automatic t_wake();
    ubrk_node_i.runs.delete();
    wreg(UBRK_OFS_CTRL, 16'h11);
    wreg(UBRK_OFS_STATUS, 16'h7);
    wreg(UBRK_OFS_TXDATA, 16'h00);
    ubrk_node_i.hold(1'b0, 3);
    chk("wake in space", 16'(wake), 16'h1);
    ubrk_node_i.hold(1'b1, 10);
    chk("wake at mark", 16'(wake), 16'h0);
    rreg(UBRK_OFS_STATUS);
    chk("no rx byte", 16'(d[UBRK_ST_RXBYTE]), 16'h0);
    chk("no tx", 16'(ubrk_node_i.runs.size()), 16'h0);
  endtask
  task automatic t_sleep();
    // a break in flight is cut off and the line returns to mark
    wreg(UBRK_OFS_CTRL, 16'h3);
    wreg(UBRK_OFS_TXDATA, 16'h00);
    tk(2 * BP);
    @(posedge clk);
    slp <= 1'b1;
    tk(4);
    chk("sleep abort", 16'(tx), 16'h1);
    ubrk_node_i.runs.delete();
    wreg(UBRK_OFS_CTRL, 16'h9);
    wreg(UBRK_OFS_STATUS, 16'h7);
    wreg(UBRK_OFS_TXDATA, 16'h00);
    ubrk_node_i.hold(1'b0, 14);
    ubrk_node_i.hold(1'b1, 2);
    rreg(UBRK_OFS_STATUS);
    chk("asleep status", d & 16'h7, 16'h0);
    chk("asleep tx", 16'(ubrk_node_i.runs.size()), 16'h0);
  endtask
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    slp = 1'b0;
    addr = 4'h0;
    wdata = 16'h0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_fixed();
    t_modes();
    t_ovr();
    t_rx();
    t_wake();
    t_sleep();
    final_report();
  end
endmodule
`default_nettype wire
